// file: power_mode_wakeup_controller.sv
// Global power mode sequencer with wakeup handling and boost regulator control
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps

module power_mode_wakeup_controller (
  input  wire logic                                sys_clk_in,       // System clock
  input  wire logic                                rst_in,           // Sync reset, high
  input  wire power_mode_pkg::bus_req_s            bus_in,           // Register access
  output logic [power_mode_pkg::DATA_W-1:0]        rdata_out,        // Read data
  input  wire logic                                periph_irq_in,    // Peripheral interrupt
  input  wire logic                                supv_irq_in,      // Power supervisor irq
  input  wire logic                                pin_irq_in,       // Pin interrupt unit
  input  wire logic                                ext_reset_pin_in, // External reset, low
  input  wire logic                                wdt_reset_in,     // Watchdog reset
  input  wire logic                                precise_low_voltage_reset_reset_in,    // Precise LV reset
  output logic [power_mode_pkg::SUBSYS_N-1:0]      clk_en_out,       // Subsystem clock enables
  output logic [1:0]                               mode_out,         // Global power mode
  output logic                                     gpio_hold_out,    // Hold GPIO outputs
  output logic                                     wake_out,         // Wakeup pulse
  output power_mode_pkg::boost_ctl_s               boost_out         // Boost controls
);
  import power_mode_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          pin_sync;
    logic [2:0]          pin_meta;
    logic [SUBSYS_N-1:0] act_tmpl;
    logic [SUBSYS_N-1:0] alt_tmpl;
    logic                cpu_force;
    logic [WAKE_N-1:0]   wake_en;
    logic [WAKE_N-1:0]   wake_cause;
    logic [VCODE_W-1:0]  vcode;
    logic                boost_stby;
    logic [15:0]         tw_period;
    logic [15:0]         tw_cnt;
    logic [1:0]          mode;
    logic [1:0]          req_mode;
    seq_state_e          state;
    logic [CNT_W-1:0]    cnt;
    logic [7:0]          bdiv;
    logic                boost_clk;
    logic [DATA_W-1:0]   rdata;
    logic [SUBSYS_N-1:0] clk_en;
    logic                wake;
    logic                hold;
    logic                stby_eff;
  } state_s;

  state_s st_reg;
  state_s st_next;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  logic [WAKE_N-1:0] src;
  logic [WAKE_N-1:0] hit_src;
  logic              tw_tick;
  logic              wake_hit;
  logic              ext_rst;
  logic              pin_irq;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.wake = 1'b0;
    st_next.pin_meta = {ext_reset_pin_in, pin_irq_in, 1'b0};
    st_next.pin_sync = st_reg.pin_meta;
    pin_irq = st_reg.pin_sync[1];
    ext_rst = ~st_reg.pin_sync[2];

    // Timewheel periodic tick, runs in every mode but hibernate
    tw_tick = 1'b0;
    if (st_reg.mode != MODE_HIB) begin
      if (st_reg.tw_cnt >= st_reg.tw_period) begin
        st_next.tw_cnt = 16'h0000;
        tw_tick = 1'b1;
      end else begin
        st_next.tw_cnt = st_reg.tw_cnt + 16'h0001;
      end
    end

    src = '0;
    src[W_PERIPH] = periph_irq_in;
    src[W_SUPV]   = supv_irq_in;
    src[W_TWHEEL] = tw_tick;
    src[W_PIN]    = pin_irq;
    src[W_EXTERNAL_RESET_PIN]   = ext_rst;
    src[W_WDT]    = wdt_reset_in;
    src[W_PRECISE_LOW_VOLTAGE_RESET]   = precise_low_voltage_reset_reset_in;

    // Only sources allowed to wake in the current mode count as hits
    if (st_reg.mode == MODE_HIB) begin
      hit_src = src & (WAKE_N'(1) << W_PIN);
    end else begin
      hit_src = src & (st_reg.wake_en | RESET_WAKE_MASK);
    end
    wake_hit = |hit_src;

    // Boost switching enable from a fixed divider
    if (st_reg.bdiv == 8'(BOOST_DIV_CYC - 1)) begin
      st_next.bdiv = 8'h00;
      st_next.boost_clk = 1'b1;
    end else begin
      st_next.bdiv = st_reg.bdiv + 8'h01;
      st_next.boost_clk = 1'b0;
    end

    // Register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        ACT_TMPL_ADDR: begin
          st_next.act_tmpl = bus_in.wdata[SUBSYS_N-1:0];
          if (bus_in.wdata[CPU_BIT]) begin
            st_next.cpu_force = 1'b0;
          end
        end
        ALT_TMPL_ADDR:  st_next.alt_tmpl = bus_in.wdata[SUBSYS_N-1:0];
        MODE_REQ_ADDR: begin
          if (st_reg.state == ST_ACTIVE && bus_in.wdata[1:0] != MODE_ACTIVE) begin
            st_next.req_mode = bus_in.wdata[1:0];
            st_next.state = ST_ENTER;
          end
        end
        WAKE_EN_ADDR:   st_next.wake_en = bus_in.wdata[WAKE_N-1:0];
        BOOST_CFG_ADDR: begin
          if (bus_in.wdata[VCODE_W-1:0] <= VCODE_MAX) begin
            st_next.vcode = bus_in.wdata[VCODE_W-1:0];
          end
          st_next.boost_stby = bus_in.wdata[BOOST_STBY_BIT];
        end
        WAKE_CAUSE_ADDR: st_next.wake_cause = st_reg.wake_cause & ~bus_in.wdata[WAKE_N-1:0];
        TW_PERIOD_ADDR:  st_next.tw_period = bus_in.wdata[15:0];
        default: ;
      endcase
    end

    // Register reads, data in the following cycle
    st_next.rdata = '0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        ACT_TMPL_ADDR:   st_next.rdata = DATA_W'(st_reg.act_tmpl);
        ALT_TMPL_ADDR:   st_next.rdata = DATA_W'(st_reg.alt_tmpl);
        MODE_REQ_ADDR:   st_next.rdata = DATA_W'(st_reg.req_mode);
        WAKE_EN_ADDR:    st_next.rdata = DATA_W'(st_reg.wake_en);
        BOOST_CFG_ADDR:  st_next.rdata = DATA_W'({st_reg.boost_stby, 2'b00, st_reg.vcode});
        STATUS_ADDR:     st_next.rdata = DATA_W'({st_reg.state, st_reg.mode});
        WAKE_CAUSE_ADDR: st_next.rdata = DATA_W'(st_reg.wake_cause);
        TW_PERIOD_ADDR:  st_next.rdata = DATA_W'(st_reg.tw_period);
        default:         st_next.rdata = '0;
      endcase
    end

    // Mode sequencer
    case (st_reg.state)
      ST_ACTIVE: begin
        if (wake_hit && st_reg.mode != MODE_ACTIVE) begin
          st_next.mode = MODE_ACTIVE;
          st_next.cpu_force = 1'b1;
          st_next.wake = 1'b1;
        end else if (wake_hit && !st_reg.act_tmpl[CPU_BIT]) begin
          st_next.cpu_force = 1'b1;
          st_next.wake = 1'b1;
        end
      end
      ST_ENTER: begin
        // Bus access has completed; commit the requested mode
        st_next.mode = st_reg.req_mode;
        st_next.state = (st_reg.req_mode == MODE_ALT) ? ST_ACTIVE : ST_LOWPOWER;
      end
      ST_LOWPOWER: begin
        if (wake_hit) begin
          st_next.state = ST_WAKE;
          st_next.cnt = (st_reg.mode == MODE_HIB) ? cyc(HIB_WAKE_CYC) : cyc(SLEEP_WAKE_CYC);
        end
      end
      ST_WAKE: begin
        if (st_reg.cnt == '0) begin
          st_next.state = ST_ACTIVE;
          st_next.mode = MODE_ACTIVE;
          st_next.cpu_force = 1'b1;
          st_next.wake = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_W'(1);
        end
      end
      default: st_next.state = ST_ACTIVE;
    endcase

    // Sticky cause: set wins over clear
    if (wake_hit && (st_reg.state == ST_LOWPOWER || st_reg.mode != MODE_ACTIVE ||
                     !st_reg.act_tmpl[CPU_BIT])) begin
      st_next.wake_cause = st_next.wake_cause | hit_src;
    end

    // Clock gating from the template of the current mode
    case (st_next.mode)
      MODE_ACTIVE: st_next.clk_en = st_next.act_tmpl;
      MODE_ALT:    st_next.clk_en = st_next.alt_tmpl;
      default:     st_next.clk_en = '0;
    endcase
    if (st_next.cpu_force && st_next.mode == MODE_ACTIVE) begin
      st_next.clk_en[CPU_BIT] = 1'b1;
    end

    // Turn the CPU off in the cycle of its own disable write, overriding cpu_force for that cycle only
    if (bus_in.wr && bus_in.addr == ACT_TMPL_ADDR && !bus_in.wdata[CPU_BIT] &&
        st_reg.mode == MODE_ACTIVE && !st_next.wake) begin
      st_next.clk_en[CPU_BIT] = 1'b0;
    end

    if (st_reg.mode == MODE_HIB && st_next.boost_stby) begin
      st_next.boost_stby = 1'b0;
    end

    // Standby only honoured in sleep; hibernate clears the standby request
    st_next.hold     = (st_next.mode == MODE_HIB);
    st_next.stby_eff = st_next.boost_stby && st_next.mode == MODE_SLEEP;
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg <= '{
        pin_sync:   3'h4,
        pin_meta:   3'h4,
        act_tmpl:   TMPL_RESET,
        alt_tmpl:   TMPL_RESET,
        cpu_force:  1'b0,
        wake_en:    WAKE_EN_RESET,
        wake_cause: '0,
        vcode:      VCODE_RESET,
        boost_stby: 1'b0,
        tw_period:  TW_PERIOD_RESET,
        tw_cnt:     16'h0000,
        mode:       MODE_ACTIVE,
        req_mode:   MODE_ACTIVE,
        state:      ST_ACTIVE,
        cnt:        '0,
        bdiv:       8'h00,
        boost_clk:  1'b0,
        rdata:      '0,
        clk_en:     TMPL_RESET,
        wake:       1'b0,
        hold:       1'b0,
        stby_eff:   1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  always_comb begin
    rdata_out     = st_reg.rdata;
    clk_en_out    = st_reg.clk_en;
    mode_out      = st_reg.mode;
    gpio_hold_out = st_reg.hold;
    wake_out      = st_reg.wake;
    boost_out.vcode = st_reg.vcode;
    boost_out.standby = st_reg.stby_eff;
    boost_out.clk = st_reg.boost_clk;
  end

endmodule : power_mode_wakeup_controller

// file: power_mode_pkg.sv
// Package with register map, field layout, modes and timing for the power mode controller
package power_mode_pkg;

  // ----------------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SLEEP_WAKE_NS   = 15_000;
  localparam int unsigned HIB_WAKE_MAX_NS = 100_000;
  localparam int unsigned BOOST_SW_HZ     = 400_000;
  localparam int unsigned NS_PER_S        = 1_000_000_000;
  localparam int unsigned SLEEP_WAKE_CYC  = (SLEEP_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HIB_WAKE_CYC    = (HIB_WAKE_MAX_NS / 2) * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned BOOST_DIV_CYC   = CLK_HZ / BOOST_SW_HZ;
  localparam int unsigned CNT_W           = 12;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ACT_TMPL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] ALT_TMPL_ADDR   = 8'h04;
  localparam logic [ADDR_W-1:0] MODE_REQ_ADDR   = 8'h08;
  localparam logic [ADDR_W-1:0] WAKE_EN_ADDR    = 8'h0c;
  localparam logic [ADDR_W-1:0] BOOST_CFG_ADDR  = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_ADDR     = 8'h14;
  localparam logic [ADDR_W-1:0] WAKE_CAUSE_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] TW_PERIOD_ADDR  = 8'h1c;

  // Subsystem template: bit 0 is the CPU
  localparam int unsigned SUBSYS_N = 8;
  localparam int unsigned CPU_BIT  = 0;
  localparam logic [SUBSYS_N-1:0] TMPL_RESET = 8'hff;

  // Wakeup sources
  localparam int unsigned WAKE_N     = 8;
  localparam int unsigned W_PERIPH   = 0;
  localparam int unsigned W_SUPV     = 1;
  localparam int unsigned W_TWHEEL   = 2;
  localparam int unsigned W_PIN      = 3;
  localparam int unsigned W_EXTERNAL_RESET_PIN     = 4;
  localparam int unsigned W_WDT      = 5;
  localparam int unsigned W_PRECISE_LOW_VOLTAGE_RESET     = 6;
  localparam logic [WAKE_N-1:0] WAKE_EN_RESET = 8'h7f;
  localparam logic [WAKE_N-1:0] RESET_WAKE_MASK = 8'h70;

  // Boost voltage code: 0 = 1.8 V, 32 = 5.0 V, 100 mV steps
  localparam int unsigned VCODE_W = 6;
  localparam logic [VCODE_W-1:0] VCODE_MAX   = 6'h20;
  localparam logic [VCODE_W-1:0] VCODE_RESET = 6'h0f;
  localparam int unsigned BOOST_STBY_BIT = 8;

  localparam logic [15:0] TW_PERIOD_RESET = 16'h00ff;

  // ----------------------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_ALT    = 2'h1,
    MODE_SLEEP  = 2'h2,
    MODE_HIB    = 2'h3
  } power_mode_e;

  typedef enum logic [2:0] {
    ST_ACTIVE   = 3'h0,
    ST_ENTER    = 3'h1,
    ST_LOWPOWER = 3'h3,
    ST_WAKE     = 3'h2
  } seq_state_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [VCODE_W-1:0] vcode;
    logic               standby;
    logic               clk;
  } boost_ctl_s;

endpackage : power_mode_pkg

// file: power_mode_asserts.sv
// Port-level checks for the power mode controller
`timescale 1ns/100ps

module power_mode_checker (
  input wire logic                                sys_clk_in,   // Clock
  input wire logic                                rst_in,       // Reset
  input wire power_mode_pkg::bus_req_s            bus_in,       // Bus
  input wire logic                                pin_irq_in,   // Pin wake
  input wire logic                                wdt_reset_in, // Watchdog
  input wire logic [power_mode_pkg::SUBSYS_N-1:0] clk_en_out,   // Enables
  input wire logic [1:0]                          mode_out,     // Mode
  input wire logic                                wake_out,     // Wake pulse
  input wire power_mode_pkg::boost_ctl_s          boost_out     // Boost
);
  import power_mode_pkg::*;

  logic [10:0] since_pin_reg;
  logic [11:0] hib_wait_reg;

  // Cycles spent in hibernate since a pin wake request arrived
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || mode_out != 2'h3) begin
      hib_wait_reg <= 12'h000;
    end else if (pin_irq_in || hib_wait_reg != 12'h000) begin
      hib_wait_reg <= hib_wait_reg + 12'h001;
    end
  end

  // Cycles since the pin wake line was last high, saturating
  always_ff @(posedge sys_clk_in) begin
    since_pin_reg <= rst_in ? 11'h7ff : pin_irq_in ? 11'h000 :
                     since_pin_reg + {10'h000, since_pin_reg != 11'h7ff};
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_mode_wr(logic [1:0] m);
    bus_in.wr && bus_in.addr == MODE_REQ_ADDR && bus_in.wdata[1:0] == m && mode_out == 2'h0;
  endsequence
  sequence s_hib_exit;
    mode_out == 2'h3 ##1 mode_out == 2'h0;
  endsequence

  property p_reset;
    disable iff (1'b0) rst_in |=> mode_out == 2'h0 && clk_en_out == TMPL_RESET && !wake_out
      && boost_out.vcode == VCODE_RESET && !boost_out.standby;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_sleep_entry;
    s_mode_wr(2'h2) |-> ##2 (mode_out == 2'h2 && clk_en_out == '0);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
  property p_sleep_wake;
    wdt_reset_in && mode_out == 2'h2 |=> ##300 mode_out == 2'h2 ##[60:90] mode_out == 2'h0;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep resume time wrong");
  property p_hib_wake;
    mode_out == 2'h3 |-> hib_wait_reg < 12'h9c4;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate resume too slow");
  property p_hib_pin_only;
    s_hib_exit |-> since_pin_reg < 11'h514;
  endproperty
  a_hib_pin_only: assert property (p_hib_pin_only) else $error("hibernate left without pin");
  property p_wake_cpu;
    wake_out |-> mode_out == 2'h0 && clk_en_out[CPU_BIT];
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("wake without cpu enable");
  property p_standby;
    boost_out.standby |-> mode_out == 2'h2;
  endproperty
  a_standby: assert property (p_standby) else $error("boost standby outside sleep");
  property p_boost_clk;
    boost_out.clk |=> !boost_out.clk ##61 boost_out.clk;
  endproperty
  a_boost_clk: assert property (p_boost_clk) else $error("boost switch period wrong");
endmodule : power_mode_checker

bind power_mode_wakeup_controller power_mode_checker power_mode_checker_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in), .pin_irq_in(pin_irq_in),
  .wdt_reset_in(wdt_reset_in), .clk_en_out(clk_en_out), .mode_out(mode_out),
  .wake_out(wake_out), .boost_out(boost_out));

// file: wake_source_model.sv
// Wakeup source model: holds one source line high for four cycles per request
`timescale 1ns/100ps

module wake_source_model (
  input  wire logic       sys_clk_in, // Clock
  input  wire logic       fire_in,    // Raise a source
  input  wire logic [2:0] src_in,     // Source index
  output logic [6:0]      line_out    // Source lines, high active
);
  import power_mode_pkg::*;

  logic [2:0]  hold_cnt = 3'h0;
  logic [2:0]  src_q    = 3'h0;
  logic [2:0]  next_src = 3'h0;
  logic [11:0] pin_gap  = 12'h000;
  logic        pend     = 1'b0;

  // A request waits until the line in use has finished its pulse
  always @(posedge sys_clk_in) begin
    if (pend && hold_cnt == 3'h0 && (next_src != W_PIN || pin_gap == 12'h000)) begin
      pend     <= 1'b0;
      hold_cnt <= 3'h4;
      src_q    <= next_src;
      // Pin pulses at least 100 us apart, below 10 kHz
      if (next_src == W_PIN) pin_gap <= 12'h9c4;
    end else begin
      if (hold_cnt != 3'h0) hold_cnt <= hold_cnt - 3'h1;
      if (pin_gap != 12'h000) pin_gap <= pin_gap - 12'h001;
    end
    if (fire_in) begin
      pend     <= 1'b1;
      next_src <= src_in;
    end
  end

  assign line_out = (hold_cnt != 3'h0) ? (7'h01 << src_q) : 7'h00;
endmodule : wake_source_model

// file: tb_top.sv
// Self-checking bench for the power mode controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  import power_mode_pkg::*;
  logic                sys_clk_in, rst_in, fire_reg, gpio_hold_out, wake_out;
  logic [2:0]          src_reg;
  logic [6:0]          src_line;
  logic [1:0]          mode_out;
  logic [DATA_W-1:0]   rdata_out;
  logic [SUBSYS_N-1:0] clk_en_out;
  bus_req_s            bus_in;
  boost_ctl_s          boost_out;
  int                  errors = 0, check_count = 0, cyc = 0, n;

  power_mode_wakeup_controller power_mode_wakeup_controller_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .periph_irq_in(src_line[W_PERIPH]), .supv_irq_in(src_line[W_SUPV]),
    .pin_irq_in(src_line[W_PIN]), .ext_reset_pin_in(~src_line[W_EXTERNAL_RESET_PIN]),
    .wdt_reset_in(src_line[W_WDT]), .precise_low_voltage_reset_reset_in(src_line[W_PRECISE_LOW_VOLTAGE_RESET]),
    .clk_en_out(clk_en_out), .mode_out(mode_out), .gpio_hold_out(gpio_hold_out),
    .wake_out(wake_out), .boost_out(boost_out));
  wake_source_model wake_source_model_i (.sys_clk_in(sys_clk_in), .fire_in(fire_reg),
    .src_in(src_reg), .line_out(src_line));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in);
    bus_in <= '0;
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk_in);
    bus_in <= '0;
    #1;
    `CHK("rdata", e, rdata_out)
  endtask : bus_rd
  task automatic fire(input int s);
    @(posedge sys_clk_in);
    fire_reg <= 1'b1;
    src_reg  <= 3'(s);
    @(posedge sys_clk_in);
    fire_reg <= 1'b0;
    #1;
  endtask : fire
  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (n = 0; mode_out !== m && n < lim; n++) tick(1);
    `CHK("mode", m, mode_out)
  endtask : wait_mode

  task automatic t_regs;
    logic [7:0]  a [8] = '{ACT_TMPL_ADDR, ALT_TMPL_ADDR, MODE_REQ_ADDR, WAKE_EN_ADDR,
                           BOOST_CFG_ADDR, STATUS_ADDR, TW_PERIOD_ADDR, 8'h40};
    logic [31:0] e [8] = '{32'hff, 32'hff, 32'h0, 32'h7f, 32'h0f, 32'h0, 32'hff, 32'h0};
    `CHK("mode", 2'h0, mode_out)
    `CHK("clk_en", TMPL_RESET, clk_en_out)
    for (int i = 0; i < 8; i++) bus_rd(a[i], e[i]);
  endtask : t_regs
  task automatic t_cpu;
    bus_wr(WAKE_EN_ADDR, 32'h7b);
    bus_wr(ACT_TMPL_ADDR, 32'h5a);
    tick(2);
    `CHK("clk_en", 8'h5a, clk_en_out)
    `CHK("clk_gate", 1'b0, clk_en_out[CPU_BIT])
    fire(W_PERIPH);
    for (n = 0; wake_out !== 1'b1 && n < 20; n++) tick(1);
    `CHK("wake", 1'b1, wake_out)
    `CHK("cpu", 8'h5b, clk_en_out)
    bus_wr(ACT_TMPL_ADDR, 32'hff);
  endtask : t_cpu
  task automatic t_alt;
    bus_wr(ALT_TMPL_ADDR, 32'h3c);
    bus_wr(MODE_REQ_ADDR, 32'h1);
    tick(1);
    `CHK("alt", 2'h1, mode_out)
    `CHK("clk_en", 8'h3c, clk_en_out)
    fire(W_SUPV);
    wait_mode(2'h0, 10);
    `CHK("clk_en", 8'hff, clk_en_out)
  endtask : t_alt
  task automatic t_boost;
    bus_wr(BOOST_CFG_ADDR, 32'h021);
    bus_rd(BOOST_CFG_ADDR, 32'h00f);
    bus_wr(BOOST_CFG_ADDR, 32'h120);
    tick(1);
    `CHK("vcode", 6'h20, boost_out.vcode)
    `CHK("standby", 1'b0, boost_out.standby)
  endtask : t_boost
  task automatic t_sleep;
    int s [6] = '{W_PIN, W_PERIPH, W_SUPV, W_EXTERNAL_RESET_PIN, W_WDT, W_PRECISE_LOW_VOLTAGE_RESET};
    foreach (s[i]) begin
      bus_wr(WAKE_CAUSE_ADDR, 32'hff);
      bus_wr(MODE_REQ_ADDR, 32'h2);
      tick(1);
      `CHK("clk_off", 8'h00, clk_en_out)
      `CHK("standby", 1'b1, boost_out.standby)
      fire(s[i]);
      wait_mode(2'h0, 420);
      `CHK("wait", 1'b1, n > 360)
      bus_rd(WAKE_CAUSE_ADDR, 32'h1 << s[i]);
    end
  endtask : t_sleep
  task automatic t_hib;
    bus_wr(MODE_REQ_ADDR, 32'h3);
    tick(1);
    `CHK("hold", 1'b1, gpio_hold_out)
    fire(W_WDT);
    fire(W_PERIPH);
    tick(300);
    `CHK("hib", 2'h3, mode_out)
    bus_rd(BOOST_CFG_ADDR, 32'h020);
    fire(W_PIN);
    wait_mode(2'h0, 2499);
    `CHK("hold", 1'b0, gpio_hold_out)
    bus_rd(ALT_TMPL_ADDR, 32'h3c);
  endtask : t_hib
  task automatic t_wheel;
    bus_wr(WAKE_CAUSE_ADDR, 32'hff);
    bus_wr(TW_PERIOD_ADDR, 32'h0f);
    bus_wr(MODE_REQ_ADDR, 32'h2);
    bus_wr(WAKE_EN_ADDR, 32'h7f);
    wait_mode(2'h0, 420);
    bus_rd(WAKE_CAUSE_ADDR, 32'h4);
  endtask : t_wheel

  task automatic summarize;
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial begin
    rst_in   = 1'b1;
    bus_in   = '0;
    fire_reg = 1'b0;
    src_reg  = 3'h0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    tick(1);
    t_regs();
    t_cpu();
    t_alt();
    t_boost();
    t_sleep();
    t_hib();
    t_wheel();
    summarize();
  end
endmodule : tb_top
